// >>> common/legacy_exc_pkg.sv
// Constants, types and helpers for the legacy-mode exception block
package legacy_exc_pkg;
	// Status longword field positions
	localparam int PSL_T   = 4;
	localparam int PSL_IV  = 5;
	localparam int PSL_FU  = 6;
	localparam int PSL_DV  = 7;
	localparam int PSL_IPL = 16;
	localparam int IPL_W   = 5;
	localparam int PSL_PRV = 22;
	localparam int PSL_CUR = 24;
	localparam int PSL_IS  = 26;
	localparam int PSL_FPD = 27;
	localparam int PSL_TP  = 30;
	localparam int PSL_CM  = 31;
	localparam logic [1:0] MODE_USER = 2'h3;

	// Fault codes
	localparam logic [15:0] CODE_RSVD = 16'h0000;
	localparam logic [15:0] CODE_BPT  = 16'h0001;
	localparam logic [15:0] CODE_IOT  = 16'h0002;
	localparam logic [15:0] CODE_EMT  = 16'h0003;
	localparam logic [15:0] CODE_UVEC = 16'h0004;
	localparam logic [15:0] CODE_ILL  = 16'h0005;
	localparam logic [15:0] CODE_ODD  = 16'h0005;

	// Frame lengths in longwords, longword size in bytes
	localparam logic [1:0]  FRAME_FAULT = 2'h3;
	localparam logic [1:0]  FRAME_TRACE = 2'h2;
	localparam logic [31:0] LW_BYTES    = 32'h0000_0004;

	// Register byte offsets
	localparam logic [7:0] REG_CTRL   = 8'h00;
	localparam logic [7:0] REG_VEC    = 8'h04;
	localparam logic [7:0] REG_KSP    = 8'h08;
	localparam logic [7:0] REG_IOBASE = 8'h0C;
	localparam logic [7:0] REG_STAT   = 8'h10;
	localparam logic [7:0] REG_PC     = 8'h14;

	// Reset values and field positions
	localparam logic [31:0] CTRL_RST     = 32'h0000_0001;
	localparam logic [31:0] VEC_RST      = 32'h0028_0010;
	localparam logic [31:0] KSP_RST      = 32'h0000_0000;
	localparam logic [31:0] IOBASE_RST   = 32'h0000_E000;
	localparam int          CTRL_LOCK_EN = 0;

	typedef enum logic [3:0] {
		CLS_PLAIN   = 4'h0,
		CLS_RETURN  = 4'h1,
		CLS_RSVD    = 4'h2,
		CLS_BPT     = 4'h3,
		CLS_IOT     = 4'h4,
		CLS_EMT     = 4'h5,
		CLS_UVEC    = 4'h6,
		CLS_JMP_REG = 4'h7,
		CLS_PREG    = 4'h8
	} insn_class_e;

	typedef enum logic [1:0] {
		KIND_FAULT = 2'h0,
		KIND_ABORT = 2'h1,
		KIND_TRAP  = 2'h2,
		KIND_NONE  = 2'h3
	} exc_kind_e;

	typedef enum logic [0:0] {
		ST_RUN  = 1'h0,
		ST_PUSH = 1'h1
	} seq_state_e;

	function automatic logic is_fault(insn_class_e c);
		return c inside {CLS_RSVD, CLS_BPT, CLS_IOT, CLS_EMT, CLS_UVEC,
			CLS_JMP_REG, CLS_PREG};
	endfunction

	function automatic logic [15:0] fault_code(insn_class_e c);
		case (c)
			CLS_BPT:     return CODE_BPT;
			CLS_IOT:     return CODE_IOT;
			CLS_EMT:     return CODE_EMT;
			CLS_UVEC:    return CODE_UVEC;
			CLS_JMP_REG: return CODE_ILL;
			default:     return CODE_RSVD;
		endcase
	endfunction

	function automatic logic [31:0] stack_psl(logic [3:0] cc, logic t,
		logic tp);
		logic [31:0] p;
		p = 32'h0000_0000;
		p[3:0] = cc;
		p[PSL_T] = t;
		p[PSL_TP] = tp;
		p[PSL_CM] = 1'b1;
		p[PSL_CUR +: 2] = MODE_USER;
		p[PSL_PRV +: 2] = MODE_USER;
		return p;
	endfunction

	function automatic logic rei_bad(logic [31:0] p);
		return p[PSL_CM] && (p[PSL_IV] || p[PSL_FU] || p[PSL_DV]
			|| (p[PSL_IPL +: IPL_W] != 5'h00) || p[PSL_IS] || p[PSL_FPD]
			|| (p[PSL_CUR +: 2] != MODE_USER)
			|| (p[PSL_PRV +: 2] != MODE_USER) || (p[15:8] != 8'h00));
	endfunction

	function automatic logic [31:0] wr_sel(logic [31:0] old,
		logic [31:0] nw, logic [3:0] sel);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++) begin
			if (sel[i]) begin
				r[i*8 +: 8] = nw[i*8 +: 8];
			end
		end
		return r;
	endfunction
endpackage

// >>> core/frame_pusher.sv
// Writes an exception frame onto the kernel stack, one longword a cycle
`timescale 1ns/1ps
module frame_pusher (
	// Clock and control
	input  wire logic        clk_i,
	input  wire logic        rst_i,
	input  wire logic        ce_i,
	input  wire logic        start_i,
	// Frame contents
	input  wire logic [1:0]  len_i,
	input  wire logic [31:0] psl_i,
	input  wire logic [31:0] pc_i,
	input  wire logic [31:0] info_i,
	input  wire logic [31:0] sp_i,
	// Stack write port
	output logic             we_o,
	output logic [31:0]      addr_o,
	output logic [31:0]      data_o,
	output logic [31:0]      sp_o,
	output logic             done_o
);
	import legacy_exc_pkg::*;

	logic [1:0] left_r;
	logic [1:0] idx_r;

	// Status first, then PC, then information longword
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			left_r <= 2'h0;
			idx_r  <= 2'h0;
			we_o   <= 1'b0;
			addr_o <= 32'h0000_0000;
			data_o <= 32'h0000_0000;
			sp_o   <= 32'h0000_0000;
			done_o <= 1'b0;
		end else if (ce_i) begin
			we_o   <= 1'b0;
			done_o <= 1'b0;
			if (start_i && left_r == 2'h0) begin
				left_r <= len_i;
				idx_r  <= 2'h0;
				sp_o   <= sp_i;
			end else if (left_r != 2'h0) begin
				we_o   <= 1'b1;
				addr_o <= sp_o - LW_BYTES;
				sp_o   <= sp_o - LW_BYTES;
				data_o <= (idx_r == 2'h0) ? psl_i :
					(idx_r == 2'h1) ? pc_i : info_i;
				idx_r  <= idx_r + 2'h1;
				left_r <= left_r - 2'h1;
				done_o <= (left_r == 2'h1);
			end
		end
	end
endmodule

// >>> core/legacy_exc_trace.sv
// Legacy-mode exception, trace and interlock sequencer with register slave
//
// The implementer's own choices: the placing of the registers and register access over Wishbone.
`timescale 1ns/1ps
// How it works
// - Any legacy-mode exception leaves legacy mode and asks the pipeline to back out
// - Legacy-specific exceptions push three longwords: status, PC, information
// - Information longword holds the code in bits 15..0, zero above
// - Legacy-specific exceptions are faults or aborts, never traps
// - Reserved legacy opcodes fault with code 0
// - Breakpoint faults with code 1, I/O vector instruction with code 2
// - Emulator group faults with code 3, user-vector group with code 4
// - Jump or subroutine jump to a register faults as illegal, code 5
// - Word reference to an odd byte address aborts with code 5
// - Trace-pending at instruction start raises a trace fault
// - Trace fault pushes status and PC; stacked priority, stack flag zero, legacy one
// - Trace fault uses the one trace vector shared with native mode
// - Odd instruction fetch abort goes ahead of the pending trace fault
// - A return popping trace-enable set traces after the next instruction
// - Exception return with trace set, pending clear runs one instruction, then traces
// - Trace set, pending clear on a plain instruction sets pending, executes
// - Same on a return instruction: it executes, sets pending, then traces
// - Stacked trace-enable after a return follows the popped word, pending clear
// - Faulting instruction with trace set: fault first, stacked pending clear
// - Only condition bits are reachable; other register references fault reserved
// - Modify accesses interlock read and write for I/O registers, never memory
// - Entry only by exception return; bad reserved fields give reserved operand
module legacy_exc_trace (
	// Clock, reset, enable
	input  wire logic                        clk_i,
	input  wire logic                        rst_i,
	input  wire logic                        ce_i,
	// Wishbone slave
	input  wire logic                        wb_cyc_i,
	input  wire logic                        wb_stb_i,
	input  wire logic                        wb_we_i,
	input  wire logic [7:0]                  wb_adr_i,
	input  wire logic [3:0]                  wb_sel_i,
	input  wire logic [31:0]                 wb_dat_i,
	output logic      [31:0]                 wb_dat_o,
	output logic                             wb_ack_o,
	// Pipeline instruction events
	input  wire logic                        insn_start_i,
	input  wire legacy_exc_pkg::insn_class_e insn_class_i,
	input  wire logic                        fetch_odd_i,
	input  wire logic                        popped_t_i,
	input  wire logic [31:0]                 psl_i,
	input  wire logic [31:0]                 pc_i,
	input  wire logic                        rei_i,
	input  wire logic [31:0]                 rei_psl_i,
	// Pipeline data references
	input  wire logic                        mem_req_i,
	input  wire logic                        mem_we_i,
	input  wire logic                        mem_word_i,
	input  wire logic                        mem_modify_i,
	input  wire logic [31:0]                 mem_addr_i,
	// Exception report
	output logic                             stall_o,
	output logic                             native_req_o,
	output logic                             exc_valid_o,
	output legacy_exc_pkg::exc_kind_e        exc_kind_o,
	output logic      [15:0]                 exc_code_o,
	output logic      [15:0]                 exc_vector_o,
	output logic                             rsvd_operand_o,
	output logic                             legacy_mode_o,
	output logic                             mem_lock_o,
	// Kernel stack write port
	output logic                             stk_we_o,
	output logic      [31:0]                 stk_addr_o,
	output logic      [31:0]                 stk_data_o
);
	import legacy_exc_pkg::*;

	logic [31:0] ctrl_r;
	logic [31:0] vec_r;
	logic [31:0] ksp_r;
	logic [31:0] iobase_r;
	logic [31:0] dat_r;
	logic        ack_r;
	logic [31:0] rd_w;
	logic        legacy_r;
	logic        t_r;
	logic        tp_r;
	logic        rsvd_op_r;
	seq_state_e  st_r;
	logic        push_start_r;
	logic        stall_r;
	logic        native_r;
	logic        exc_valid_r;
	exc_kind_e   kind_r;
	logic [15:0] vecout_r;
	logic [1:0]  len_r;
	logic [31:0] psl_r;
	logic [31:0] pc_r;
	logic [31:0] info_r;
	logic        lock_r;
	logic        push_done_w;
	logic [31:0] push_sp_w;
	logic        run;
	logic        ins;
	logic        ev_fodd;
	logic        ev_trace;
	logic        ev_fault;
	logic        ev_dodd;
	logic        ev_any;
	logic        plain_ok;
	logic        rei_go;
	logic        io_hit;
	logic        wb_req;

	// Event decode
	always_comb begin
		run      = ce_i && st_r == ST_RUN;
		ins      = run && insn_start_i && legacy_r;
		ev_fodd  = ins && fetch_odd_i;
		ev_trace = ins && !fetch_odd_i && tp_r;
		ev_fault = ins && !fetch_odd_i && !tp_r
			&& is_fault(insn_class_i);
		ev_dodd  = run && legacy_r && !insn_start_i && mem_req_i
			&& mem_word_i && mem_addr_i[0];
		ev_any   = ev_fodd || ev_trace || ev_fault || ev_dodd;
		plain_ok = ins && !ev_any;
		rei_go   = run && rei_i && !legacy_r;
		io_hit   = mem_addr_i[31:16] >= iobase_r[15:0];
		wb_req   = wb_cyc_i && wb_stb_i;
	end

	// Register read mux
	always_comb begin
		case (wb_adr_i)
			REG_CTRL:   rd_w = ctrl_r;
			REG_VEC:    rd_w = vec_r;
			REG_KSP:    rd_w = ksp_r;
			REG_IOBASE: rd_w = iobase_r;
			REG_STAT:   rd_w = {info_r[15:0], 11'h000, lock_r, stall_r,
				tp_r, t_r, legacy_r};
			REG_PC:     rd_w = pc_r;
			default:    rd_w = 32'h0000_0000;
		endcase
	end

	// Wishbone slave and software registers
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ack_r    <= 1'b0;
			dat_r    <= 32'h0000_0000;
			ctrl_r   <= CTRL_RST;
			vec_r    <= VEC_RST;
			ksp_r    <= KSP_RST;
			iobase_r <= IOBASE_RST;
		end else if (ce_i) begin
			ack_r <= wb_req && !ack_r;
			if (wb_req && !ack_r) begin
				dat_r <= rd_w;
			end
			if (wb_req && ack_r && wb_we_i) begin
				case (wb_adr_i)
					REG_CTRL:   ctrl_r <= wr_sel(ctrl_r, wb_dat_i, wb_sel_i);
					REG_VEC:    vec_r <= wr_sel(vec_r, wb_dat_i, wb_sel_i);
					REG_KSP:    ksp_r <= wr_sel(ksp_r, wb_dat_i, wb_sel_i);
					REG_IOBASE: iobase_r <= wr_sel(iobase_r, wb_dat_i,
						wb_sel_i);
					default:    ;
				endcase
			end
			if (push_done_w) begin
				ksp_r <= push_sp_w;
			end
		end
	end

	// Mode, trace-enable and trace-pending
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			legacy_r  <= 1'b0;
			t_r       <= 1'b0;
			tp_r      <= 1'b0;
			rsvd_op_r <= 1'b0;
		end else if (ce_i) begin
			rsvd_op_r <= 1'b0;
			if (ev_any) begin
				legacy_r <= 1'b0;
				t_r      <= 1'b0;
				tp_r     <= 1'b0;
			end else if (plain_ok) begin
				if (t_r && !tp_r) begin
					tp_r <= 1'b1;
				end
				if (insn_class_i == CLS_RETURN) begin
					t_r <= popped_t_i;
				end
			end else if (rei_go) begin
				if (rei_bad(rei_psl_i)) begin
					rsvd_op_r <= 1'b1;
				end else begin
					legacy_r <= rei_psl_i[PSL_CM];
					t_r      <= rei_psl_i[PSL_T];
					tp_r     <= rei_psl_i[PSL_TP];
				end
			end
		end
	end

	// Exception sequencer and frame contents
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			st_r         <= ST_RUN;
			push_start_r <= 1'b0;
			stall_r      <= 1'b0;
			native_r     <= 1'b0;
			exc_valid_r  <= 1'b0;
			kind_r       <= KIND_NONE;
			vecout_r     <= 16'h0000;
			len_r        <= 2'h0;
			psl_r        <= 32'h0000_0000;
			pc_r         <= 32'h0000_0000;
			info_r       <= 32'h0000_0000;
		end else if (ce_i) begin
			push_start_r <= 1'b0;
			exc_valid_r  <= 1'b0;
			native_r     <= ev_any;
			unique case (st_r)
				ST_RUN: if (ev_any) begin
					st_r         <= ST_PUSH;
					push_start_r <= 1'b1;
					stall_r      <= 1'b1;
					pc_r         <= {16'h0000, pc_i[15:0]};
					if (ev_fodd || ev_dodd) begin
						kind_r   <= KIND_ABORT;
						info_r   <= {16'h0000, CODE_ODD};
						len_r    <= FRAME_FAULT;
						vecout_r <= vec_r[15:0];
						psl_r    <= stack_psl(psl_i[3:0], t_r, tp_r);
					end else if (ev_trace) begin
						kind_r   <= KIND_FAULT;
						info_r   <= 32'h0000_0000;
						len_r    <= FRAME_TRACE;
						vecout_r <= vec_r[31:16];
						psl_r    <= stack_psl(psl_i[3:0], t_r, 1'b0);
					end else begin
						kind_r   <= KIND_FAULT;
						info_r   <= {16'h0000, fault_code(insn_class_i)};
						len_r    <= FRAME_FAULT;
						vecout_r <= vec_r[15:0];
						psl_r    <= stack_psl(psl_i[3:0], t_r, 1'b0);
					end
				end
				ST_PUSH: if (push_done_w) begin
					st_r        <= ST_RUN;
					stall_r     <= 1'b0;
					exc_valid_r <= 1'b1;
				end
			endcase
		end
	end

	// Read-modify-write interlock on legacy I/O registers
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			lock_r <= 1'b0;
		end else if (ce_i) begin
			if (mem_req_i && legacy_r && mem_modify_i && !mem_we_i && io_hit
				&& ctrl_r[CTRL_LOCK_EN]) begin
				lock_r <= 1'b1;
			end else if (mem_req_i && mem_we_i) begin
				lock_r <= 1'b0;
			end
		end
	end

	frame_pusher u_pusher (
		.clk_i   (clk_i),
		.rst_i   (rst_i),
		.ce_i    (ce_i),
		.start_i (push_start_r),
		.len_i   (len_r),
		.psl_i   (psl_r),
		.pc_i    (pc_r),
		.info_i  (info_r),
		.sp_i    (ksp_r),
		.we_o    (stk_we_o),
		.addr_o  (stk_addr_o),
		.data_o  (stk_data_o),
		.sp_o    (push_sp_w),
		.done_o  (push_done_w)
	);

	assign wb_dat_o       = dat_r;
	assign wb_ack_o       = ack_r;
	assign stall_o        = stall_r;
	assign native_req_o   = native_r;
	assign exc_valid_o    = exc_valid_r;
	assign exc_kind_o     = kind_r;
	assign exc_code_o     = info_r[15:0];
	assign exc_vector_o   = vecout_r;
	assign rsvd_operand_o = rsvd_op_r;
	assign legacy_mode_o  = legacy_r;
	assign mem_lock_o     = lock_r;

	// Checks
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i || !ce_i);

	sequence s_push3;
		push_start_r ##2 stk_we_o [*3] ##1 !stk_we_o;
	endsequence

	sequence s_push2;
		push_start_r ##2 stk_we_o [*2] ##1 !stk_we_o;
	endsequence

	a_leave_legacy: assert property (ev_any |=> !legacy_r ##[1:8] exc_valid_o)
		else $error("exception did not leave legacy mode and report");
	a_fault_frame: assert property (ev_fault |=> s_push3)
		else $error("fault frame is not three longwords");
	a_info_upper: assert property (ev_fault |=> ##4 (stk_we_o
		&& stk_data_o[31:16] == 16'h0000))
		else $error("information longword upper half not zero");
	a_never_trap: assert property (exc_valid_o |-> exc_kind_o != KIND_TRAP)
		else $error("legacy exception reported as trap");
	a_rsvd_code: assert property (ev_fault && insn_class_i == CLS_RSVD
		|=> info_r == 32'h0000_0000)
		else $error("reserved opcode code not 0");
	a_bpt_iot_code: assert property (ev_fault && insn_class_i inside
		{CLS_BPT, CLS_IOT} |=> info_r[15:0] ==
		($past(insn_class_i == CLS_BPT) ? 16'h0001 : 16'h0002))
		else $error("breakpoint or I/O vector code wrong");
	a_group_code: assert property (ev_fault && insn_class_i inside
		{CLS_EMT, CLS_UVEC} |=> info_r[15:0] ==
		($past(insn_class_i == CLS_EMT) ? 16'h0003 : 16'h0004))
		else $error("emulator or user-vector code wrong");
	a_jmp_reg_code: assert property (ev_fault && insn_class_i == CLS_JMP_REG
		|=> info_r[15:0] == 16'h0005 && kind_r == KIND_FAULT)
		else $error("register jump code not 5");
	a_odd_abort: assert property (ev_dodd |=> kind_r == KIND_ABORT
		&& info_r[15:0] == 16'h0005 ##0 s_push3)
		else $error("odd address abort wrong");
	a_trace_frame: assert property (ev_trace |=> psl_r[PSL_CM]
		&& psl_r[PSL_IPL +: IPL_W] == 5'h00 && !psl_r[PSL_IS]
		&& !psl_r[PSL_TP] && vecout_r == vec_r[31:16] ##0 s_push2)
		else $error("trace frame wrong");
	a_fetch_first: assert property (ins && fetch_odd_i && tp_r
		|=> kind_r == KIND_ABORT)
		else $error("odd fetch not ahead of trace");
	a_sets_pending: assert property (plain_ok && t_r && !tp_r |=> tp_r)
		else $error("trace pending not set");
	a_return_t: assert property (plain_ok && insn_class_i == CLS_RETURN
		|=> t_r == $past(popped_t_i))
		else $error("return did not load trace enable");
	a_fault_psl: assert property (ev_fault && t_r |=> psl_r[PSL_T]
		&& !psl_r[PSL_TP] && !tp_r)
		else $error("faulting traced instruction stacked wrong");
	a_rei_check: assert property (rei_go && rei_bad(rei_psl_i)
		|=> rsvd_operand_o && !legacy_mode_o)
		else $error("bad exception return image accepted");
	a_lock_io_only: assert property ($rose(lock_r) |-> $past(io_hit
		&& mem_modify_i && legacy_r))
		else $error("interlock set outside I/O space");
endmodule

// >>> testbench/stack_model.sv
// Kernel stack memory model that stores exception frame writes
`timescale 1ns/1ps
module stack_model (
	// Clock
	input  wire logic        clk_i,
	// Stack write port
	input  wire logic        we_i,
	input  wire logic [31:0] addr_i,
	input  wire logic [31:0] data_i
);
	logic [31:0] mem [0:63];
	// Longword store, indexed by word address
	always @(posedge clk_i) begin
		if (we_i === 1'b1) begin
			mem[addr_i[7:2]] <= data_i;
		end
	end
endmodule

// >>> testbench/tb.sv
// Self-checking bench for the legacy exception and trace sequencer
`timescale 1ns/1ps
module tb;
	import legacy_exc_pkg::*;
	logic        clk_i, rst_i, ce_i, cyc, stb, we, ack;
	logic        start, odd, popt, exception_return_insn, mreq, mwe, mword, mmod;
	logic        stall, nreq, valid, rsvd, legacy, lock, swe, nseen;
	logic [7:0]  adr;
	logic [3:0]  sel;
	logic [31:0] wdat, rdat, cur_st, pc, rei_st, maddr, sadr, sdat, q;
	logic [15:0] code, vec;
	insn_class_e cls;
	exc_kind_e   kind;
	int          error_cnt, comparisons;

	legacy_exc_trace dut (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i),
		.wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
		.wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
		.insn_start_i(start), .insn_class_i(cls), .fetch_odd_i(odd),
		.popped_t_i(popt), .psl_i(cur_st), .pc_i(pc), .rei_i(exception_return_insn),
		.rei_psl_i(rei_st), .mem_req_i(mreq), .mem_we_i(mwe),
		.mem_word_i(mword), .mem_modify_i(mmod), .mem_addr_i(maddr),
		.stall_o(stall), .native_req_o(nreq), .exc_valid_o(valid),
		.exc_kind_o(kind), .exc_code_o(code), .exc_vector_o(vec),
		.rsvd_operand_o(rsvd), .legacy_mode_o(legacy), .mem_lock_o(lock),
		.stk_we_o(swe), .stk_addr_o(sadr), .stk_data_o(sdat));
	stack_model m (.clk_i(clk_i), .we_i(swe), .addr_i(sadr), .data_i(sdat));

	initial begin
		clk_i = 0;
		forever #2 clk_i = ~clk_i;
	end
	always @(posedge clk_i) begin
		if (nreq === 1'b1) nseen <= 1'b1;
	end

	task chk(input logic [31:0] g, input logic [31:0] e);
		comparisons++;
		if (g !== e) begin
			error_cnt++;
			$display("unexpected at %0t: got %h expected %h", $time, g, e);
		end
	endtask
	task summarize;
		$display("mismatches %0d comparisons %0d", error_cnt, comparisons);
		if (error_cnt == 0 && comparisons > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask
	task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		@(posedge clk_i);
		cyc <= 1;
		stb <= 1;
		we <= w;
		adr <= a;
		wdat <= d;
		n = 0;
		do begin
			@(posedge clk_i);
			n++;
		end while (ack !== 1'b1 && n < 20);
		q = rdat;
		cyc <= 0;
		stb <= 0;
		we <= 0;
		if (n >= 20) begin
			error_cnt++;
			summarize;
		end
	endtask
	task rd(input logic [7:0] a, input logic [31:0] e);
		wb(0, a, 32'h0);
		chk(q, e);
	endtask
	function automatic logic [31:0] st_exp(logic t, logic tp);
		logic [31:0] s;
		s = {28'h0, cur_st[3:0]};
		s[PSL_T] = t;
		s[PSL_TP] = tp;
		s[PSL_CM] = 1'b1;
		s[PSL_CUR +: 2] = 2'h3;
		s[PSL_PRV +: 2] = 2'h3;
		return s;
	endfunction
	task prep;
		wb(1, REG_KSP, 32'h0000_0100);
		for (int j = 61; j < 64; j++) m.mem[j] = 32'hDEAD_BEEF;
		nseen = 0;
	endtask
	task enter(input logic t, input logic bad);
		logic [31:0] s;
		s = 32'h0;
		s[PSL_CM] = 1'b1;
		s[PSL_CUR +: 2] = 2'h3;
		s[PSL_PRV +: 2] = 2'h3;
		s[PSL_T] = t;
		s[PSL_IS] = bad;
		@(posedge clk_i);
		rei_st <= s;
		exception_return_insn <= 1;
		@(posedge clk_i);
		exception_return_insn <= 0;
		@(negedge clk_i);
		chk(rsvd, bad);
		chk(legacy, !bad);
	endtask
	task insn(input insn_class_e c, input logic o, input logic pt);
		@(posedge clk_i);
		cls <= c;
		odd <= o;
		popt <= pt;
		start <= 1;
		@(posedge clk_i);
		start <= 0;
		odd <= 0;
	endtask
	task mref(input logic w, input logic md, input logic [31:0] a);
		@(posedge clk_i);
		mreq <= 1;
		mwe <= w;
		mmod <= md;
		maddr <= a;
		@(posedge clk_i);
		mreq <= 0;
		@(negedge clk_i);
	endtask
	task frame(input logic [15:0] ec, input logic [31:0] st,
		input exc_kind_e k, input int len);
		int n;
		n = 0;
		do begin
			@(negedge clk_i);
			n++;
		end while (valid !== 1'b1 && n < 20);
		if (n >= 20) begin
			error_cnt++;
			summarize;
		end
		chk(nseen, 1'b1);
		chk(legacy, 1'b0);
		chk(kind, k);
		chk(m.mem[63], st);
		chk(m.mem[62], {16'h0, pc[15:0]});
		if (len == 3) chk(code, ec);
		if (len == 3) chk(m.mem[61], {16'h0, ec});
		chk(vec, (len == 3) ? 16'h0010 : 16'h0028);
		rd(REG_KSP, 32'h0000_0100 - 4 * len);
	endtask

	task t_regs;
		rd(REG_CTRL, CTRL_RST);
		rd(REG_VEC, VEC_RST);
		rd(REG_KSP, KSP_RST);
		rd(REG_IOBASE, IOBASE_RST);
		wb(1, 8'h20, 32'hFFFF_FFFF);
		rd(8'h20, 32'h0);
	endtask
	task t_faults;
		insn_class_e cl [7];
		logic [15:0] cd [7];
		cl = '{CLS_RSVD, CLS_BPT, CLS_IOT, CLS_EMT, CLS_UVEC, CLS_JMP_REG,
			CLS_PREG};
		cd = '{16'h0000, 16'h0001, 16'h0002, 16'h0003, 16'h0004, 16'h0005,
			16'h0000};
		for (int i = 0; i < 7; i++) begin
			prep;
			enter(i[0], 0);
			insn(cl[i], 0, 0);
			frame(cd[i], st_exp(i[0], 0), KIND_FAULT, 3);
		end
	endtask
	task t_odd_data;
		prep;
		enter(0, 0);
		mref(0, 0, 32'h0000_0101);
		frame(16'h0005, st_exp(0, 0), KIND_ABORT, 3);
	endtask
	task t_trace;
		prep;
		enter(1, 0);
		insn(CLS_PLAIN, 0, 0);
		@(negedge clk_i);
		chk(stall, 1'b0);
		insn(CLS_PLAIN, 0, 0);
		frame(16'h0, st_exp(1, 0), KIND_FAULT, 2);
	endtask
	task t_return;
		for (int p = 0; p < 2; p++) begin
			prep;
			enter(1, 0);
			insn(CLS_RETURN, 0, p[0]);
			insn(CLS_PLAIN, 0, 0);
			frame(16'h0, st_exp(p[0], 0), KIND_FAULT, 2);
		end
	endtask
	task t_odd_fetch;
		prep;
		enter(1, 0);
		insn(CLS_PLAIN, 0, 0);
		insn(CLS_PLAIN, 1, 0);
		frame(16'h0005, st_exp(1, 1), KIND_ABORT, 3);
		rd(REG_PC, {16'h0, pc[15:0]});
		rd(REG_STAT, {CODE_ODD, 16'h0000});
	endtask
	task t_lock;
		enter(0, 1);
		enter(0, 0);
		mref(0, 1, 32'hE000_0010);
		chk(lock, 1'b1);
		@(posedge clk_i);
		ce_i <= 0;
		mref(1, 0, 32'hE000_0010);
		chk(lock, 1'b1);
		@(posedge clk_i);
		ce_i <= 1;
		mref(1, 0, 32'hE000_0010);
		chk(lock, 1'b0);
		mref(0, 1, 32'h0000_0010);
		chk(lock, 1'b0);
	endtask

	initial begin
		error_cnt = 0;
		comparisons = 0;
		nseen = 0;
		rst_i = 1;
		ce_i = 1;
		cyc = 0;
		stb = 0;
		we = 0;
		adr = 8'h00;
		sel = 4'hF;
		wdat = 32'h0;
		start = 0;
		cls = CLS_PLAIN;
		odd = 0;
		popt = 0;
		cur_st = 32'h0000_0005;
		pc = 32'hABCD_1234;
		exception_return_insn = 0;
		rei_st = 32'h0;
		mreq = 0;
		mwe = 0;
		mword = 1;
		mmod = 0;
		maddr = 32'h0;
		repeat (3) @(posedge clk_i);
		rst_i <= 0;
		t_regs;
		t_faults;
		t_odd_data;
		t_trace;
		t_return;
		t_odd_fetch;
		t_lock;
		summarize;
	end
endmodule
